// ==== src/i2c_target_pkg.sv ====
/*
  Shared constants, state encoding and address decoding for the I2C register
  pointer target and its scratch register store.
  Assumes a single system clock domain for the store; the link side runs on SCL.
*/
// Overview of operation
// - Works at Standard and Fast bus rates.
// - Answers only bus address 0x32.
// - Pointer increments after each data byte.
// - STOP ends transfer, back to idle.
// - Pointer wraps from FF to 00.
// - Scratch registers 0x88 to 0x8B read back.
package i2c_target_pkg;

  // ***************************************************************
  // Bus addressing and register map
  // ***************************************************************
  localparam logic [6:0] DEV_ADDR = 7'h32;
  localparam logic READ_DIR = 1'b1;
  localparam logic [7:0] SCRATCH_BASE = 8'h88;
  localparam logic [7:0] SCRATCH_LAST = 8'h8b;
  localparam int SCRATCH_CNT = 4;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ***************************************************************
  // Bit framing on the link
  // ***************************************************************
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic SDA_LOW = 1'b0;

  // ***************************************************************
  // Transfer states, Gray coded along idle, address, pointer, write
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_PTR   = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6,
    ST_SKIP  = 3'h7
  } xfer_state_e;

  // True when the pointer selects one of the scratch registers.
  function automatic logic is_scratch(input logic [7:0] addr);
    return (addr >= SCRATCH_BASE) && (addr <= SCRATCH_LAST);
  endfunction

  // Index of the scratch register selected by the pointer.
  function automatic logic [1:0] scratch_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - SCRATCH_BASE;
    return diff[1:0];
  endfunction

endpackage

// ==== src/reg_access_if.sv ====
/*
  Register access carrier between the protocol engine and the scratch store.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
interface reg_access_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport store (input wr_en, input addr, input wdata, output rdata);
  modport user (output wr_en, output addr, output wdata, input rdata);
endinterface

// ==== src/scratch_store.sv ====
/*
  Scratch register store: four byte registers with a registered read port.
  Assumes a synchronous active-high reset on the system clock.
*/
`timescale 1ns/100ps
module scratch_store (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  reg_access_if.store acc
);

  // ***************************************************************
  // Storage
  // ***************************************************************
  logic [7:0] scratch_reg [i2c_target_pkg::SCRATCH_CNT];
  logic [7:0] rdata_reg;
  wire hit_scratch = i2c_target_pkg::is_scratch(acc.addr);
  wire [1:0] hit_index = i2c_target_pkg::scratch_index(acc.addr);

  // Each scratch byte keeps whatever value the master wrote.
  for (genvar g = 0; g < i2c_target_pkg::SCRATCH_CNT; g++)
  begin : g_scratch
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
        scratch_reg[g] <= i2c_target_pkg::SCRATCH_RESET;
      else if (acc.wr_en && hit_scratch && (hit_index == 2'(g)))
        scratch_reg[g] <= acc.wdata;
    end
  end

  // Read data comes from a register; unmodelled addresses read zero.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rdata_reg <= i2c_target_pkg::UNMAPPED_READ;
    else
      rdata_reg <= hit_scratch ? scratch_reg[hit_index] : i2c_target_pkg::UNMAPPED_READ;
  end

  assign acc.rdata = rdata_reg;

  // ***************************************************************
  // Checks
  // ***************************************************************
  // The pointer steps in the cycle of the write, so the stored byte is
  // checked at the index that was selected when the strobe came.
  a_scratch_echo: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (acc.wr_en && hit_scratch) |=> (scratch_reg[$past(hit_index)] == $past(acc.wdata)))
    else $error("scratch register did not keep the written byte");

  a_scratch_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hit_scratch |=> (acc.rdata == $past(scratch_reg[hit_index])))
    else $error("scratch read port did not show the selected byte");

endmodule

// ==== src/i2c_register_pointer_target.sv ====
/*
  I2C target with an auto-incrementing 8-bit register pointer.
  The bit shifter and SDA driver run on SCL; framing, pointer and register
  access run on the system clock. Assumes an external pull-up on SDA, an SCL
  that only the master drives, and a system clock much faster than SCL.
  SCL must stand still between transfers: the link logic is cleared
  asynchronously on START and STOP and has no other way back to idle.
  There is no clock stretching, so the master sets the pace alone.
*/
`timescale 1ns/100ps
module i2c_register_pointer_target (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  reg_access_if acc ();

  // System domain.
  i2c_target_pkg::xfer_state_e state_reg;
  i2c_target_pkg::xfer_state_e state_next;
  logic [2:0] sync_meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] sync_prev_reg;
  logic link_clr_reg;
  logic rst_link_reg;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic ack_en_reg;
  logic ack_en_next;
  logic tx_en_reg;

  // Link domain.
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic nack_reg;
  logic byte_tog_reg;
  logic sda_oe_reg;

  // ***************************************************************
  // Input synchronisers and bus condition detection
  // ***************************************************************
  // SCL, SDA and the byte toggle pass two flops; a third stage gives edges.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sync_meta_reg <= 3'h3;
      sync_reg <= 3'h3;
      sync_prev_reg <= 3'h3;
    end
    else
    begin
      sync_meta_reg <= {byte_tog_reg, sda_i, scl_i};
      sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_reg;
    end
  end

  wire scl_s = sync_reg[0];
  wire sda_s = sync_reg[1];
  wire sda_p = sync_prev_reg[1];
  wire start_det = scl_s && sda_p && !sda_s;
  wire stop_det = scl_s && !sda_p && sda_s;
  wire byte_ev = sync_reg[2] ^ sync_prev_reg[2];

  // Clearing the link logic from a flop keeps its asynchronous clear glitch
  // free; the detection latency of a few system cycles is far inside the
  // START hold time at 400 kHz, which sets the top bus rate.
  // The limitation is that SCL must stay well below a tenth of the system
  // clock, or the sampled SCL and SDA levels miss short phases.
  // The link reset is delayed a cycle too, so both domains leave reset
  // from a registered edge rather than straight from the pin.
  always_ff @(posedge clk_sys_i)
  begin
    link_clr_reg <= rst_i || start_det || stop_det;
    rst_link_reg <= rst_i;
  end

  // ***************************************************************
  // Link domain: bit shifter on SCL rising edges
  // ***************************************************************
  // Data is taken on the rising edge; the ninth clock samples the master's
  // acknowledge so a NACK stops further transmission.
  // The SCL rise that belongs to a repeated START or a STOP counts one bit
  // here; the clear that follows the detected condition undoes it before
  // the next real bit arrives.
  always_ff @(posedge scl_i or posedge link_clr_reg)
  begin
    if (link_clr_reg)
    begin
      bit_cnt_reg <= i2c_target_pkg::BIT_FIRST;
      shift_reg <= i2c_target_pkg::PTR_RESET;
      nack_reg <= 1'b0;
    end
    else if (bit_cnt_reg == i2c_target_pkg::ACK_SLOT)
    begin
      bit_cnt_reg <= i2c_target_pkg::BIT_FIRST;
      nack_reg <= sda_i;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + i2c_target_pkg::BIT_STEP;
      shift_reg <= {shift_reg[6:0], sda_i};
    end
  end

  // The toggle survives START and STOP so the system side never sees a
  // spurious byte event when the link logic is cleared.
  always_ff @(posedge scl_i or posedge rst_link_reg)
  begin
    if (rst_link_reg)
      byte_tog_reg <= 1'b0;
    else if (bit_cnt_reg == i2c_target_pkg::BIT_LAST)
      byte_tog_reg <= ~byte_tog_reg;
  end

  // ***************************************************************
  // Link domain: SDA driver on SCL falling edges
  // ***************************************************************
  // The ack and transmit enables are system flops that settle a few system cycles
  // after an SCL rise, well before the falling edge reads them, so they are stable there.
  wire [2:0] bit_idx = 3'(i2c_target_pkg::BIT_LAST - bit_cnt_reg);
  wire tx_bit = acc.rdata[bit_idx];
  wire tx_go = tx_en_reg && !nack_reg;

  always_ff @(negedge scl_i or posedge link_clr_reg)
  begin
    if (link_clr_reg)
      sda_oe_reg <= 1'b0;
    else if (bit_cnt_reg == i2c_target_pkg::ACK_SLOT)
      sda_oe_reg <= ack_en_reg;
    else
      sda_oe_reg <= tx_go && !tx_bit;
  end

  // The pin is open drain: the value is always low and only the enable
  // moves, so the device can never drive SDA high against another party.
  assign sda_o = i2c_target_pkg::SDA_LOW;
  assign sda_oe_o = sda_oe_reg;

  // ***************************************************************
  // System domain: transfer sequencing
  // ***************************************************************
  wire addr_match = (shift_reg[7:1] == i2c_target_pkg::DEV_ADDR);
  wire addr_read = (shift_reg[0] == i2c_target_pkg::READ_DIR);
  wire in_data = (state_reg == i2c_target_pkg::ST_WDATA) || (state_reg == i2c_target_pkg::ST_RDATA);

  // START, repeated or not, always reopens address decoding; STOP wins idle.
  always_comb
  begin
    state_next = state_reg;
    if (stop_det)
      state_next = i2c_target_pkg::ST_IDLE;
    else if (start_det)
      state_next = i2c_target_pkg::ST_ADDR;
    else if (byte_ev)
    begin
      unique case (state_reg)
        i2c_target_pkg::ST_ADDR:
        begin
          if (!addr_match)
            state_next = i2c_target_pkg::ST_SKIP;
          else if (addr_read)
            state_next = i2c_target_pkg::ST_RDATA;
          else
            state_next = i2c_target_pkg::ST_PTR;
        end
        i2c_target_pkg::ST_PTR: state_next = i2c_target_pkg::ST_WDATA;
        i2c_target_pkg::ST_IDLE,
        i2c_target_pkg::ST_WDATA,
        i2c_target_pkg::ST_RDATA,
        i2c_target_pkg::ST_SKIP: state_next = state_reg;
        default: state_next = i2c_target_pkg::ST_IDLE;
      endcase
    end
  end

  // The pointer stays between transfers, so a read can follow a write that
  // only set it; the 8-bit sum wraps FF to 00 by itself.
  assign ptr_next = (byte_ev && (state_reg == i2c_target_pkg::ST_PTR)) ? shift_reg :
                    (byte_ev && in_data) ? ptr_reg + i2c_target_pkg::PTR_STEP :
                    ptr_reg;

  // Acknowledge our address, the pointer byte and every data byte written.
  assign ack_en_next = (start_det || stop_det) ? 1'b0 :
                       !byte_ev ? ack_en_reg :
                       ((state_reg == i2c_target_pkg::ST_ADDR) && addr_match) ||
                       (state_reg == i2c_target_pkg::ST_PTR) ||
                       (state_reg == i2c_target_pkg::ST_WDATA);

  // The transmit enable is taken from the next state so that it is already
  // settled when the first falling SCL edge of a read byte samples it.
  // A START or STOP drops it in the same cycle as the acknowledge enable.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_reg <= i2c_target_pkg::ST_IDLE;
      ptr_reg <= i2c_target_pkg::PTR_RESET;
      ack_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      ack_en_reg <= ack_en_next;
      tx_en_reg <= (state_next == i2c_target_pkg::ST_RDATA);
    end
  end

  // ***************************************************************
  // Register access
  // ***************************************************************
  // A data byte lands at the current pointer in the same cycle that the
  // pointer steps, so the store sees the old value. Configuration registers
  // are not modelled, which also keeps host writes from disturbing them.
  assign acc.wr_en = byte_ev && (state_reg == i2c_target_pkg::ST_WDATA);
  assign acc.addr = ptr_reg;
  assign acc.wdata = shift_reg;

  scratch_store u_store (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .acc(acc)
  );

  // ***************************************************************
  // Checks
  // ***************************************************************
  // All checks watch the system domain; link flops are read here only where
  // they sit still for a whole SCL half period.
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_addr_ignore: assert property (
    (byte_ev && !start_det && !stop_det && state_reg == i2c_target_pkg::ST_ADDR && !addr_match)
    |=> (state_reg == i2c_target_pkg::ST_SKIP) && !ack_en_reg)
    else $error("foreign address was not ignored");

  a_ptr_step: assert property (
    (byte_ev && in_data) |=> (ptr_reg == 8'($past(ptr_reg) + i2c_target_pkg::PTR_STEP)))
    else $error("pointer did not step after a data byte");

  a_ptr_wrap: assert property (
    (byte_ev && in_data && ptr_reg == 8'hff) |=> (ptr_reg == 8'h00))
    else $error("pointer did not wrap to zero");

  // STOP clears the link logic through its flop in the following cycle.
  a_stop_idle: assert property (
    stop_det |=> (state_reg == i2c_target_pkg::ST_IDLE) && link_clr_reg)
    else $error("stop did not return to idle");

  a_ptr_load: assert property (
    (byte_ev && !start_det && !stop_det && state_reg == i2c_target_pkg::ST_PTR)
    |=> (ptr_reg == $past(shift_reg)) && (state_reg == i2c_target_pkg::ST_WDATA))
    else $error("first write byte did not load the pointer");

  a_ack_own: assert property (
    (byte_ev && !start_det && !stop_det && state_reg == i2c_target_pkg::ST_ADDR && addr_match)
    |=> ack_en_reg)
    else $error("own address was not acknowledged");

  // The read address is acknowledged; every read byte after it is not.
  a_read_noack: assert property (
    (byte_ev && !start_det && !stop_det && state_reg == i2c_target_pkg::ST_RDATA)
    |=> !ack_en_reg && tx_en_reg)
    else $error("read phase drove an acknowledge");

  a_start_addr: assert property (
    (start_det && !stop_det) |=> (state_reg == i2c_target_pkg::ST_ADDR) && !ack_en_reg)
    else $error("start did not reopen address decoding");

  // A foreign transfer must neither acknowledge nor transmit.
  a_skip_quiet: assert property (
    (state_reg == i2c_target_pkg::ST_SKIP) |-> !ack_en_reg && !tx_en_reg)
    else $error("foreign transfer enabled the data line");

  // After the master refuses a byte the data line stays released.
  a_nack_release: assert property (
    nack_reg |-> !sda_oe_reg)
    else $error("data line held after the master refused a byte");

  // START or STOP withdraws both enables before the next falling SCL edge.
  a_cond_release: assert property (
    (start_det || stop_det) |=> !tx_en_reg && !ack_en_reg)
    else $error("enables stayed up across a bus condition");

  // Main scenarios: read, write, wrap, foreign address and repeated START.
  c_read_byte: cover property (byte_ev && state_reg == i2c_target_pkg::ST_RDATA);
  c_write_byte: cover property (byte_ev && state_reg == i2c_target_pkg::ST_WDATA);
  c_ptr_wrap: cover property (byte_ev && in_data && ptr_reg == 8'hff);
  c_skip_addr: cover property (state_reg == i2c_target_pkg::ST_SKIP);
  c_repeated_start: cover property (start_det && state_reg == i2c_target_pkg::ST_WDATA);

endmodule

// ==== verification/i2c_host_model.sv ====
/*
  Behavioural bus master that plays the host controller on the two-wire link.
  Assumes the bench resolves SDA from every open-drain enable with a pull-up.
*/
`timescale 1ns/100ps
module i2c_host_model (
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  // Quarter bus period in ns: 625 for 400 kHz, 2500 for 100 kHz; the bench
  // changes it only while the bus is idle. SCL stands still between frames.
  int qtr = 625;

  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // One SCL pulse; SDA is sampled in the middle of the high phase.
  task automatic pulse(output logic smp);
    #qtr scl_o = 1'b1;
    #qtr smp = sda_i;
    #qtr scl_o = 1'b0;
    #qtr;
  endtask

  // START, or repeated START when SCL is low; used before the read address.
  task automatic start();
    sda_oe_o = 1'b0;
    #qtr scl_o = 1'b1;
    #qtr sda_oe_o = 1'b1;
    #qtr scl_o = 1'b0;
    #qtr;
  endtask

  // STOP followed by bus free time.
  task automatic stop();
    sda_oe_o = 1'b1;
    #qtr scl_o = 1'b1;
    #qtr sda_oe_o = 1'b0;
    #(2 * qtr);
  endtask

  // Byte out MSB first, then the acknowledge slot with SDA released.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--)
    begin
      sda_oe_o = ~b[i];
      pulse(smp);
    end
    sda_oe_o = 1'b0;
    pulse(ack);
  endtask

  // Byte in, then ACK or, on the last byte, NACK; rel is the wire in that slot.
  task automatic recv_byte(input logic last, output logic [7:0] b, output logic rel);
    logic smp;
    sda_oe_o = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(smp);
      b[i] = smp;
    end
    sda_oe_o = ~last;
    pulse(rel);
    sda_oe_o = 1'b0;
  endtask
endmodule

// ==== verification/testbench.sv ====
/*
  Self-checking bench for the register pointer target, with a reference model.
  Assumes the host model file is compiled first; SDA has a pull-up.
*/
`timescale 1ns/100ps
module testbench;
  logic clk_sys_i;
  logic rst_i;
  logic scl;
  logic host_oe;
  logic sda_o;
  logic sda_oe_o;
  wire logic sda_line;
  int err_total;
  int tests_run;
  int ref_mem [256];
  int ref_ptr;
  logic [7:0] dq [$];

  // Open-drain wire: low when any party pulls, else the pull-up wins.
  assign sda_line = ~(host_oe | (sda_oe_o & ~sda_o));

  i2c_register_pointer_target i2c_register_pointer_target_inst (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o)
  );

  i2c_host_model i2c_host_model_inst (
    .scl_o(scl),
    .sda_oe_o(host_oe),
    .sda_i(sda_line)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // ***************************************************************
  // Checking and transfer tasks
  // ***************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Write transfer; a foreign address must leave model and device untouched.
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr);
    logic ack;
    logic hit;
    hit = (dev === i2c_target_pkg::DEV_ADDR);
    i2c_host_model_inst.start();
    i2c_host_model_inst.send_byte({dev, 1'b0}, ack);
    chk({7'h00, ack}, {7'h00, ~hit}, "address ack");
    i2c_host_model_inst.send_byte(ptr, ack);
    chk({7'h00, ack}, {7'h00, ~hit}, "pointer ack");
    if (hit)
      ref_ptr = ptr;
    foreach (dq[i])
    begin
      i2c_host_model_inst.send_byte(dq[i], ack);
      chk({7'h00, ack}, {7'h00, ~hit}, "data ack");
      if (hit && ref_ptr >= 'h88 && ref_ptr <= 'h8b)
        ref_mem[ref_ptr] = dq[i];
      if (hit)
        ref_ptr = (ref_ptr + 1) % 256;
    end
    i2c_host_model_inst.stop();
  endtask

  // Read transfer, optionally loading the pointer first.
  task automatic rd(input bit set_ptr, input logic [7:0] ptr, input int n);
    logic ack;
    logic rel;
    logic [7:0] b;
    i2c_host_model_inst.start();
    if (set_ptr)
    begin
      i2c_host_model_inst.send_byte({i2c_target_pkg::DEV_ADDR, 1'b0}, ack);
      i2c_host_model_inst.send_byte(ptr, ack);
      ref_ptr = ptr;
      i2c_host_model_inst.start();
    end
    i2c_host_model_inst.send_byte({i2c_target_pkg::DEV_ADDR, 1'b1}, ack);
    chk({7'h00, ack}, 8'h00, "read address ack");
    for (int i = 0; i < n; i++)
    begin
      i2c_host_model_inst.recv_byte(i == n - 1, b, rel);
      chk(b, 8'(ref_mem[ref_ptr]), "read data");
      ref_ptr = (ref_ptr + 1) % 256;
    end
    chk({7'h00, rel}, 8'h01, "release after nack");
    i2c_host_model_inst.stop();
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    err_total = 0;
    tests_run = 0;
    rst_i = 1'b1;
    void'($urandom(32'hc53b));
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rd(1'b1, 8'h88, 4);
    $display("test reset values done");
    // Host writes stay inside the scratch block.
    dq = {};
    for (int i = 0; i < 4; i++)
      dq.push_back(8'($urandom));
    wr(i2c_target_pkg::DEV_ADDR, 8'h88);
    rd(1'b1, 8'h86, 8);
    $display("test burst done");
    dq = {};
    wr(i2c_target_pkg::DEV_ADDR, 8'h89);
    rd(1'b0, 8'h00, 2);
    $display("test retained pointer done");
    dq = {8'($urandom)};
    for (int k = 0; k < 3; k++)
      wr(i2c_target_pkg::DEV_ADDR ^ 7'(1 << k), 8'h88);
    rd(1'b0, 8'h00, 1);
    rd(1'b1, 8'h88, 4);
    $display("test foreign address done");
    rd(1'b1, 8'hfe, 3);
    rd(1'b0, 8'h00, 1);
    $display("test wrap done");
    // One write and read back at the Standard mode rate.
    i2c_host_model_inst.qtr = 2500;
    dq = {8'($urandom)};
    wr(i2c_target_pkg::DEV_ADDR, 8'h8a);
    rd(1'b1, 8'h8a, 1);
    i2c_host_model_inst.qtr = 625;
    $display("test standard mode done");
    conclude();
  end

  // Watchdog: the transfers above need about two milliseconds, about a third of it
  // in the Standard mode test; three leave a margin.
  initial
  begin
    #3000000;
    err_total++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
